/* File: hdl/ptc_fifo.v */
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ptc_fifo #(
    parameter WIDTH = 66,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] level
);
    reg [AW:0] wr_ptr_r;
    reg [AW:0] rd_ptr_r;
    reg out_valid_r;
    wire [AW:0] cnt;
    wire push;
    wire pop_mem;
    wire [AW-1:0] rd_addr;
    wire [AW-1:0] held_addr;

    assign cnt = wr_ptr_r - rd_ptr_r;
    // the held output word keeps its slot, so it counts toward full
    assign level = cnt + {{AW{1'b0}}, out_valid_r};
    assign in_ready = (level < DEPTH);
    assign push = in_valid && in_ready;
    // move a word into the output register when it is free or drained
    assign pop_mem = (cnt != {(AW+1){1'b0}}) && (!out_valid_r || out_ready);
    // re-read the held word's slot while stalled so the data stay put
    assign held_addr = rd_ptr_r[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
    assign rd_addr = pop_mem ? rd_ptr_r[AW-1:0] : held_addr;
    assign out_valid = out_valid_r;

    ptc_fifo_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (
        .core_clk(core_clk),
        .wr_en(push),
        .wr_addr(wr_ptr_r[AW-1:0]),
        .wr_data(in_data),
        .rd_addr(rd_addr),
        .rd_data(out_data)
    );

    // pointer and output valid tracking
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
            out_valid_r <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop_mem)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
                out_valid_r <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/ptc_fifo_mem.v */
// small register-read memory that holds fifo words
`timescale 1ns/1ps
`default_nettype none
module ptc_fifo_mem #(
    parameter WIDTH = 66,
    parameter AW = 4
) (
    input wire core_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // write port and registered read port
    always @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* File: hdl/ptc_regs.vh */
// register offsets, field positions, reset values and widths for ptp tx config
`ifndef PTC_REGS_VH
`define PTC_REGS_VH
`define PTC_ADDR_W 4
`define PTC_OFS_CTRL 4'h0
`define PTC_OFS_LATENCY 4'h1
`define PTC_OFS_RESERVED 4'h2
`define PTC_OFS_STATUS 4'h3
`define PTC_OFS_TIMER 4'h4
`define PTC_OFS_FIFO_LVL 4'h5
`define PTC_CTRL_ONE_STEP_BIT 0
`define PTC_CTRL_TRANSP_BIT 1
`define PTC_CTRL_PREAMBLE_BIT 2
`define PTC_CTRL_PINCHAR0_BIT 3
`define PTC_CTRL_PINCHAR1_BIT 4
`define PTC_CTRL_RESET_BIT 5
`define PTC_CTRL_RST 6'h20
`define PTC_LAT_RST 11'h2C1
`define PTC_LAT_FRAC_W 3
`define PTC_FILL_RST 2'h0
`define PTC_AMTH_RST 9'h46
`define PTC_RES_FILL_LSB 0
`define PTC_RES_AMTH_LSB 8
`define PTC_TS_W 64
`define PTC_DATA_W 64
`define PTC_FIFO_DEPTH 16
`define PTC_FIFO_AW 4
`define PTC_CF_OFFSET 4'h3
`define PTC_PREAMBLE 64'hD555555555555555
`endif

/* File: hdl/ptc_tx_ts.v */
// transmit ptp timestamp configuration and insertion path
//
// Summary of operation
// RULE_01 - one-step enable inserts timestamp, default off
// RULE_02 - transparent mode enables correction field updates
// RULE_03 - transparent mode treats timer as correction value
// RULE_04 - transparent mode overwrites frame correction field
// RULE_05 - user timers and timestamps in correction format
// RULE_06 - latency adjust: bits 10:3 ns, 3 fractional
// RULE_07 - one-step stamp shifted by latency, default 705
// RULE_08 - software should use 802 in transparent mode
// RULE_09 - fec fill adjust reserved, hold zero
// RULE_10 - fec marker threshold reserved, hold 46 hex
// RULE_11 - custom preamble enable, default standard preamble
// RULE_12 - pin characterisation test settings held false
// RULE_13 - change settings only while path in reset
// RULE_14 - settings captured in tx domain after reset
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.vh"
module ptc_tx_ts (
    input wire core_clk,
    input wire rst_n,
    input wire [`PTC_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [`PTC_TS_W-1:0] sys_timer,
    input wire in_valid,
    output reg in_ready,
    input wire [`PTC_DATA_W-1:0] in_data,
    input wire in_sop,
    input wire in_eop,
    output reg out_valid,
    input wire out_ready,
    output reg [`PTC_DATA_W-1:0] out_data,
    output reg out_sop,
    output reg out_eop,
    output reg [`PTC_TS_W-1:0] ts_out,
    output reg ts_valid,
    output reg one_step_ts_enable,
    output reg transparent_clock_mode,
    output reg custom_preamble_enable,
    output reg [10:0] one_step_latency_adjust,
    output reg [1:0] fec_fill_adjust_reserved,
    output reg [8:0] fec_marker_threshold_reserved,
    output reg pin_char_test_ctl_reserved
);
    localparam ST_IDLE = 3'b001;
    localparam ST_BODY = 3'b010;
    localparam ST_HOLD = 3'b100;
    localparam DW = `PTC_DATA_W;

    // software-side shadow settings
    reg [5:0] ctrl_r;
    reg [10:0] lat_r;
    reg [1:0] fill_r;
    reg [8:0] amth_r;
    // tx-domain applied settings
    reg one_step_r;
    reg transp_r;
    reg preamble_r;
    reg [10:0] lat_app_r;
    reg path_rst_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [3:0] word_idx_r;
    reg [`PTC_TS_W-1:0] stamp_r;
    reg [31:0] frames_r;
    reg [31:0] rdata_nxt;
    wire [DW+1:0] fifo_in;
    wire [DW+1:0] fifo_out;
    wire fifo_out_valid;
    wire fifo_in_ready;
    wire fifo_pop;
    wire [`PTC_FIFO_AW:0] fifo_level;
    wire tx_rst;
    reg [DW-1:0] word_mod;
    wire stamp_on;
    wire [`PTC_TS_W-1:0] stamp_calc;

    // latency in ns with 3 fractional bits, scaled to 1/16 ns units
    function [`PTC_TS_W-1:0] lat_to_sub_ns;
        input [10:0] lat;
        begin
            lat_to_sub_ns = {{(`PTC_TS_W-12){1'b0}}, lat, 1'b0}; // see RULE_06
        end
    endfunction

    // correction value: timer plus adjust; tod: timer plus adjust as well
    function [`PTC_TS_W-1:0] stamp_fn;
        input [`PTC_TS_W-1:0] timer;
        input [10:0] lat;
        begin
            stamp_fn = timer + lat_to_sub_ns(lat); // see RULE_07
        end
    endfunction

    // path reset bit of the control word holds the datapath idle
    assign tx_rst = ctrl_r[`PTC_CTRL_RESET_BIT];
    // either one-step or transparent mode rewrites the field word
    assign stamp_on = one_step_r || transp_r;
    assign stamp_calc = stamp_fn(sys_timer, lat_app_r);

    // register writes; settings shadow takes writes at any time, the applied copies change only during path reset
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `PTC_CTRL_RST;
            lat_r <= `PTC_LAT_RST;
            fill_r <= `PTC_FILL_RST;
            amth_r <= `PTC_AMTH_RST;
        end
        else if (reg_wr && reg_addr == `PTC_OFS_CTRL)
        begin
            ctrl_r <= reg_wdata[5:0];
        end
        else if (reg_wr && reg_addr == `PTC_OFS_LATENCY)
        begin
            lat_r <= reg_wdata[10:0];
        end
        else if (reg_wr && reg_addr == `PTC_OFS_RESERVED)
        begin
            fill_r <= reg_wdata[`PTC_RES_FILL_LSB+1:`PTC_RES_FILL_LSB];
            amth_r <= reg_wdata[`PTC_RES_AMTH_LSB+8:`PTC_RES_AMTH_LSB];
        end
    end

    // settings applied only while the path is in reset, frozen after
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            one_step_r <= 1'b0;
            transp_r <= 1'b0;
            preamble_r <= 1'b0;
            lat_app_r <= `PTC_LAT_RST;
            path_rst_r <= 1'b1;
        end
        else
        begin
            path_rst_r <= tx_rst;
            // copies stay frozen while the path runs
            if (tx_rst)
            begin
                one_step_r <= ctrl_r[`PTC_CTRL_ONE_STEP_BIT]; // see RULE_14
                transp_r <= ctrl_r[`PTC_CTRL_TRANSP_BIT]; // see RULE_14
                preamble_r <= ctrl_r[`PTC_CTRL_PREAMBLE_BIT];
                lat_app_r <= lat_r;
            end
        end
    end

    // configuration outputs to the datapath
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            one_step_ts_enable <= 1'b0;
            transparent_clock_mode <= 1'b0;
            custom_preamble_enable <= 1'b0;
            one_step_latency_adjust <= `PTC_LAT_RST;
            fec_fill_adjust_reserved <= `PTC_FILL_RST;
            fec_marker_threshold_reserved <= `PTC_AMTH_RST;
            pin_char_test_ctl_reserved <= 1'b0;
        end
        else
        begin
            one_step_ts_enable <= one_step_r; // see RULE_01
            transparent_clock_mode <= transp_r; // see RULE_02
            custom_preamble_enable <= preamble_r; // see RULE_11
            one_step_latency_adjust <= lat_app_r;
            fec_fill_adjust_reserved <= fill_r;
            fec_marker_threshold_reserved <= amth_r;
            pin_char_test_ctl_reserved <= ctrl_r[`PTC_CTRL_PINCHAR0_BIT] |
                ctrl_r[`PTC_CTRL_PINCHAR1_BIT];
        end
    end

    // frame buffer: sop and eop ride with each word
    assign fifo_in = {in_sop, in_eop, in_data};

    ptc_fifo #(.WIDTH(DW+2), .DEPTH(`PTC_FIFO_DEPTH),
        .AW(`PTC_FIFO_AW)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(in_valid && in_ready),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    // output stage takes a word whenever it is empty or drained
    // nothing leaves the buffer while the path is held in reset
    assign fifo_pop = !path_rst_r && (!out_valid || out_ready) &&
        state_r != ST_HOLD;

    // word rewrite: preamble on the start word, stamp at the field word
    always @*
    begin
        word_mod = fifo_out[DW-1:0];
        if (fifo_out[DW+1])
        begin
            if (preamble_r)
            begin
                word_mod = `PTC_PREAMBLE; // see RULE_11
            end
        end
        else if (word_idx_r == `PTC_CF_OFFSET && stamp_on)
        begin
            // new correction value or one-step stamp replaces the field
            word_mod = stamp_r; // see RULE_04
        end
    end

    // frame state machine
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (fifo_pop && fifo_out_valid && fifo_out[DW+1] &&
                    !fifo_out[DW])
                begin
                    state_nxt = ST_BODY;
                end
            end
            ST_BODY:
            begin
                if (fifo_pop && fifo_out_valid && fifo_out[DW])
                begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_HOLD:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // datapath registers
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            word_idx_r <= 4'h0;
            stamp_r <= {`PTC_TS_W{1'b0}};
            out_valid <= 1'b0;
            out_data <= {DW{1'b0}};
            out_sop <= 1'b0;
            out_eop <= 1'b0;
            ts_out <= {`PTC_TS_W{1'b0}};
            ts_valid <= 1'b0;
            in_ready <= 1'b0;
            frames_r <= 32'h0;
        end
        else if (path_rst_r)
        begin
            state_r <= ST_IDLE;
            word_idx_r <= 4'h0;
            out_valid <= 1'b0;
            ts_valid <= 1'b0;
            in_ready <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            in_ready <= fifo_in_ready && (fifo_level < `PTC_FIFO_DEPTH - 1);
            ts_valid <= 1'b0;
            if (fifo_pop)
            begin
                out_valid <= fifo_out_valid;
                if (fifo_out_valid)
                begin
                    out_data <= word_mod;
                    out_sop <= fifo_out[DW+1];
                    out_eop <= fifo_out[DW];
                    if (fifo_out[DW+1])
                    begin
                        // timer is tod or correction value by mode
                        stamp_r <= stamp_calc; // see RULE_03
                        word_idx_r <= 4'h1;
                    end
                    else if (word_idx_r != 4'hF)
                    begin
                        word_idx_r <= word_idx_r + 4'h1;
                    end
                    if (fifo_out[DW])
                    begin
                        ts_out <= stamp_r;
                        ts_valid <= 1'b1;
                        frames_r <= frames_r + 32'h1;
                    end
                end
            end
        end
    end

    // register read mux
    always @*
    begin
        rdata_nxt = 32'h0;
        case (reg_addr)
            `PTC_OFS_CTRL: rdata_nxt = {26'h0, ctrl_r};
            `PTC_OFS_LATENCY: rdata_nxt = {21'h0, lat_r};
            `PTC_OFS_RESERVED: rdata_nxt = {15'h0, amth_r, 6'h0, fill_r};
            `PTC_OFS_STATUS: rdata_nxt = frames_r;
            `PTC_OFS_TIMER: rdata_nxt = stamp_r[31:0];
            `PTC_OFS_FIFO_LVL: rdata_nxt = {27'h0, fifo_level};
            default: rdata_nxt = 32'h0;
        endcase
    end

    // read data stand the cycle after the strobe only
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 32'h0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
        end
    end
endmodule
`default_nettype wire

/* File: verif/ptc_tx_ts_asserts.sv */
// port-level assertions for the ptp transmit configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.vh"
module ptc_tx_ts_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [63:0] out_data,
    input wire logic out_sop,
    input wire logic out_eop,
    input wire logic ts_valid,
    input wire logic one_step_ts_enable,
    input wire logic transparent_clock_mode,
    input wire logic custom_preamble_enable,
    input wire logic [10:0] one_step_latency_adjust,
    input wire logic [8:0] fec_marker_threshold_reserved
);
    logic [5:0] ctl_r;
    logic [10:0] lat_r;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // shadow copies of the control and latency words
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_r <= 6'h20;
            lat_r <= 11'h2C1;
        end
        else if (reg_wr && reg_addr == 4'h0)
            ctl_r <= reg_wdata[5:0];
        else if (reg_wr && reg_addr == 4'h1)
            lat_r <= reg_wdata[10:0];
    end
    sequence s_release;
        $fell(ctl_r[5]);
    endsequence
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    a_reset_vals: assert property (
        $rose(rst_n) |-> one_step_latency_adjust == 11'h2C1 &&
        fec_marker_threshold_reserved == 9'h46 && !one_step_ts_enable &&
        !transparent_clock_mode && !custom_preamble_enable)
        else $error("bad reset settings");
    a_cfg_frozen: assert property (
        !ctl_r[5] && !$past(ctl_r[5]) && !$past(ctl_r[5], 2) |->
        $stable({one_step_ts_enable, transparent_clock_mode,
        custom_preamble_enable, one_step_latency_adjust}))
        else $error("setting moved while running");
    a_cfg_apply: assert property (
        s_release |-> ##[0:2] (one_step_ts_enable == ctl_r[0] &&
        transparent_clock_mode == ctl_r[1] &&
        custom_preamble_enable == ctl_r[2]))
        else $error("control bits not applied");
    a_lat_apply: assert property (
        s_release |-> ##[0:2] one_step_latency_adjust == lat_r)
        else $error("latency not applied");
    a_ready_held: assert property (
        ctl_r[5] && $past(ctl_r[5]) && $past(ctl_r[5], 2) |-> !in_ready)
        else $error("input taken while held");
    a_ready_rise: assert property (
        s_release |-> ##[1:3] in_ready)
        else $error("input not ready after release");
    a_out_hold: assert property (@(posedge core_clk)
        disable iff (!rst_n || ctl_r[5])
        s_stall |=> out_valid && $stable(out_data) && $stable(out_sop))
        else $error("output changed while stalled");
    a_sop_pream: assert property (
        out_valid && out_sop && custom_preamble_enable |->
        out_data == `PTC_PREAMBLE)
        else $error("start word is not the preamble");
    a_ts_eop: assert property (
        ts_valid |-> out_valid && out_eop)
        else $error("stamp not reported at frame end");
endmodule
bind ptc_tx_ts ptc_tx_ts_asserts chk_u (.core_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .in_ready, .out_valid, .out_ready, .out_data,
    .out_sop, .out_eop, .ts_valid, .one_step_ts_enable,
    .transparent_clock_mode,
    .custom_preamble_enable, .one_step_latency_adjust,
    .fec_marker_threshold_reserved);
`default_nettype wire

/* File: verif/ptc_user_side.sv */
// user side model: frame source, system timer and a stalling sink
`timescale 1ns/1ps
`default_nettype none
module ptc_user_side (
    input wire logic core_clk,
    input wire logic stall,
    input wire logic in_ready,
    output logic in_valid,
    output logic [63:0] in_data,
    output logic in_sop,
    output logic in_eop,
    output logic [63:0] sys_timer,
    output logic out_ready,
    input wire logic out_valid,
    input wire logic [63:0] out_data
);
    logic [63:0] got[$];
    // idle levels at time zero
    initial
    begin
        in_valid = 1'b0;
        in_data = 64'h0;
        in_sop = 1'b0;
        in_eop = 1'b0;
        sys_timer = 64'h0;
        out_ready = 1'b1;
    end
    // sink takes a word on each handshake and stalls when asked
    always @(posedge core_clk)
    begin
        if (out_valid && out_ready)
            got.push_back(out_data);
        out_ready <= !stall;
    end
    // one frame; the timer is a correction value held over the frame
    task automatic send(input int n, input logic [63:0] b,
        input logic [63:0] t);
        sys_timer <= t;
        for (int k = 0; k < n; k++)
        begin
            in_valid <= 1'b1;
            in_data <= b + k;
            in_sop <= (k == 0);
            in_eop <= (k == n - 1);
            @(posedge core_clk);
            while (!in_ready)
                @(posedge core_clk);
        end
        in_valid <= 1'b0;
        in_data <= ~(b + n - 1); // released bus shows no stale word
    endtask
endmodule
`default_nettype wire

/* File: verif/ptp_tx_timestamp_config_test.sv */
// self-checking bench for the ptp transmit configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ptc_regs.vh"
module ptp_tx_timestamp_config_test;
    logic core_clk, rst_n, reg_wr, reg_rd, stall, in_valid, in_ready;
    logic in_sop, in_eop, out_valid, out_ready, out_sop, out_eop;
    logic one_step_ts_enable, transparent_clock_mode, custom_preamble_enable;
    logic pin_char_test_ctl_reserved;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [63:0] in_data, out_data, sys_timer, base, tmr, exp, ts_out;
    logic [10:0] one_step_latency_adjust, lat;
    logic [8:0] fec_marker_threshold_reserved;
    logic [1:0] fec_fill_adjust_reserved;
    int errors, checks, cycles, c, i;
    ptc_tx_ts dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .sys_timer, .in_valid, .in_ready, .in_data,
        .in_sop, .in_eop, .out_valid, .out_ready, .out_data, .out_sop,
        .out_eop, .ts_out, .ts_valid(), .one_step_ts_enable,
        .transparent_clock_mode, .custom_preamble_enable,
        .one_step_latency_adjust, .fec_fill_adjust_reserved,
        .fec_marker_threshold_reserved, .pin_char_test_ctl_reserved);
    ptc_user_side user_u (.core_clk, .stall, .in_ready, .in_valid, .in_data,
        .in_sop, .in_eop, .sys_timer, .out_ready, .out_valid, .out_data);
    // 100 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever
            #5 core_clk = ~core_clk;
    end
    // cuts a hung run short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end
    task automatic test_done;
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
        @(posedge core_clk);
    endtask
    task automatic drain(input int n);
        for (int k = 0; k < 200 && user_u.got.size() < n; k++)
            @(posedge core_clk);
        check(user_u.got.size(), n);
    endtask
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        stall = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check(fec_fill_adjust_reserved, 2'h0);
        check(fec_marker_threshold_reserved, 9'h46);
        check(pin_char_test_ctl_reserved, 1'b0);
        rd(4'h0, 32'h20);
        rd(4'h1, 32'h2C1);
        rd(4'h2, 32'h4600);
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF, 32'h0);
        rd(4'h0, 32'h20);
        for (c = 0; c < 5; c++)
        begin
            lat = c[1] ? 11'h322 : 11'h2C1;
            wr(4'h0, 32'h20 | c);
            wr(4'h1, {21'h0, lat});
            wr(4'h0, c);
            repeat (3) @(posedge core_clk);
            check(one_step_ts_enable, c[0]);
            check(transparent_clock_mode, c[1]);
            check(custom_preamble_enable, c[2]);
            check(one_step_latency_adjust, lat);
            user_u.got.delete();
            base = 64'h0101000000000000 * (c + 1);
            tmr = base + 64'h100;
            user_u.send(5, base, tmr);
            drain(5);
            for (i = 0; i < 5; i++)
            begin
                exp = base + i;
                if (i == 0 && c[2])
                    exp = `PTC_PREAMBLE;
                if (i == 3 && c[1:0] != 2'h0)
                    exp = tmr + {lat, 1'b0};
                check(user_u.got[i], exp);
            end
            exp = tmr + {lat, 1'b0};
            check(ts_out, exp);
            rd(4'h4, exp[31:0]);
            rd(4'h3, c + 1);
        end
        wr(4'h0, 32'h1);
        repeat (3) @(posedge core_clk);
        check(one_step_ts_enable, 1'b0);
        check(custom_preamble_enable, 1'b1);
        rd(4'h0, 32'h1);
        wr(4'h0, 32'h20);
        wr(4'h0, 32'h0);
        repeat (3) @(posedge core_clk);
        user_u.got.delete();
        stall <= 1'b1;
        fork
            user_u.send(24, 64'h55, 64'h0);
        join_none
        for (i = 0; i < 100 && in_ready; i++)
            @(posedge core_clk);
        @(posedge core_clk);
        check(in_ready, 1'b0);
        rd(4'h5, 32'h10);
        stall <= 1'b0;
        drain(24);
        for (i = 0; i < 24; i++)
            check(user_u.got[i], 64'h55 + i);
        check(ts_out, {52'h0, 11'h2C1, 1'b0});
        rd(4'h3, 32'h6);
        rd(4'h5, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
